/* logic/mds_pkg.sv */
// package of constants and types for the per-axis drive state machine
// assumes one axis per instance, indices in the profile area of the object table
package mds_pkg;

	// ------------------------------------------------------------------
	// object indices (axis 1) and per-axis displacement
	// ------------------------------------------------------------------
	localparam logic [15:0] IDX_ERROR_CODE   = 16'h603F;	// axis_error_code, read only
	localparam logic [15:0] IDX_COMMAND_WORD = 16'h6040;	// drive_command_word, read/write
	localparam logic [15:0] IDX_STATUS_WORD  = 16'h6041;	// status word, read only
	localparam logic [15:0] IDX_PROFILE_BASE = 16'h6000;	// first index of the axis 1 area
	localparam logic [15:0] IDX_PROFILE_SPAN = 16'h07FF;	// last offset inside one axis area
	localparam logic [15:0] IDX_AXIS_STRIDE  = 16'h0800;	// displacement between axes

	// ------------------------------------------------------------------
	// command word bit positions
	// ------------------------------------------------------------------
	localparam int CW_SWITCH_ON   = 0;
	localparam int CW_EN_VOLTAGE  = 1;
	localparam int CW_QUICK_STOP  = 2;
	localparam int CW_EN_OPER     = 3;
	localparam int CW_FAULT_RESET = 7;
	localparam int CW_HALT        = 8;
	localparam logic [15:0] CW_RESET = 16'h0000;	// command word after reset

	// ------------------------------------------------------------------
	// status word bit positions
	// ------------------------------------------------------------------
	localparam int SW_READY      = 0;
	localparam int SW_SWITCHED   = 1;
	localparam int SW_OPER_EN    = 2;
	localparam int SW_FAULT      = 3;
	localparam int SW_VOLTAGE    = 4;
	localparam int SW_QUICK_STOP = 5;
	localparam int SW_SO_DISABLE = 6;

	// ------------------------------------------------------------------
	// alarm codes raised by the state machine itself
	// ------------------------------------------------------------------
	localparam logic [15:0] ALM_BUS_ERROR  = 16'h0081;	// link left operational while running
	localparam logic [15:0] ALM_POWER_OFF  = 16'h0023;	// main power lost while running
	localparam logic [15:0] ERR_NONE       = 16'h0000;	// error code after reset

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ          = 25_000_000;	// system clock rate
	localparam int EXCITE_TIME_MS  = 250;		// excitation settling time
	localparam int EXCITE_CYCLES_D = EXCITE_TIME_MS * (CLK_HZ / 1000);

	// ------------------------------------------------------------------
	// drive states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_NOT_READY  = 8'h01,
		ST_SO_DISABLE = 8'h02,
		ST_READY      = 8'h04,
		ST_SWITCHED   = 8'h08,
		ST_OPER_EN    = 8'h10,
		ST_QUICK_STOP = 8'h20,
		ST_FAULT_REAC = 8'h40,
		ST_FAULT      = 8'h80
	} mds_state_t;

	// ------------------------------------------------------------------
	// command decoders, bits 3..0 of the command word
	// ------------------------------------------------------------------
	function automatic logic cw_shutdown(input logic [15:0] cw);
		cw_shutdown = cw[CW_QUICK_STOP] & cw[CW_EN_VOLTAGE] & ~cw[CW_SWITCH_ON];
	endfunction

	function automatic logic cw_switch_on(input logic [15:0] cw);
		cw_switch_on = ~cw[CW_EN_OPER] & cw[CW_QUICK_STOP] & cw[CW_EN_VOLTAGE]
			& cw[CW_SWITCH_ON];
	endfunction

	function automatic logic cw_enable_op(input logic [15:0] cw);
		cw_enable_op = cw[CW_EN_OPER] & cw[CW_QUICK_STOP] & cw[CW_EN_VOLTAGE]
			& cw[CW_SWITCH_ON];
	endfunction

	function automatic logic cw_dis_voltage(input logic [15:0] cw);
		cw_dis_voltage = ~cw[CW_EN_VOLTAGE];
	endfunction

	function automatic logic cw_quick_stop(input logic [15:0] cw);
		cw_quick_stop = ~cw[CW_QUICK_STOP] & cw[CW_EN_VOLTAGE];
	endfunction

endpackage

/* logic/mds_sync.sv */
// two-flop synchroniser for a group of level inputs from pins
// assumes the inputs are slow levels; a pulse shorter than one clock can be lost
module mds_sync
	import mds_pkg::*;
#(
	parameter int WIDTH = 4	// number of levels
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;	// first stage, read only by the second

	// ------------------------------------------------------------------
	// two stages
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

/* logic/mds_excite_timer.sv */
// settling timer started on entry to operation enabled
// assumes run stays high for as long as the drive is in that state
module mds_excite_timer
	import mds_pkg::*;
#(
	parameter int CYCLES = EXCITE_CYCLES_D	// cycles until excitation is complete
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// control
	input  wire logic run,
	output logic      done
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_ff;	// cycles spent running

	// ------------------------------------------------------------------
	// count while running, restart from zero when run drops
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || !run)
		begin
			cnt_ff <= '0;
			done   <= 1'b0;
		end
		else if (!done)
		begin
			cnt_ff <= cnt_ff + CW'(1);
			done   <= (cnt_ff == LAST);
		end
	end

endmodule

/* logic/mds_drive_fsm.sv */
// per-axis drive state machine: command word decode, guards, link and power
// loss handling, alarms, excitation and the per-axis object access port
// assumes pins pass through synchronisers here; init_done, motor_stopped,
// alarm_in and alarm_code come from logic on the same clock
//
// Overview of operation
// - later axes sit 800h above the previous
// - eight states, excitation in three of them
// - refuse writes while not ready
// - decode shutdown, switch on, enable operation
// - pattern 1111 in ready goes straight through
// - decode disable voltage and quick stop
// - fault reset only on rising bit 7
// - ready to switched on needs four guards
// - command ready 250 ms after operation enabled
// - reset to not ready, init then disabled
// - quick stop to disabled once stopped
// - alarm: fault reaction, stop, then fault
// - switched on falls back to ready on loss
// - operation enabled to ready on release or on loss at standstill
// - link loss while running raises alarm 81h
// - power loss while running raises alarm 23h
// - quick stop to disabled on release or on loss at standstill
// - command word bit layout
// - read-only error code object per axis
// - status word reports state in bits 6..0
module mds_drive_fsm
	import mds_pkg::*;
#(
	parameter int AXIS_NUM      = 1,		// axis number, 1 to 4
	parameter int EXCITE_CYCLES = EXCITE_CYCLES_D	// excitation settling cycles
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// pin levels, asynchronous
	input  wire logic        comm_operational,	// link state machine in operational
	input  wire logic        main_power_on,		// main power present
	input  wire logic        motor_release,		// motor-release input on
	input  wire logic        remote_test_active,	// remote test operation running
	// same-clock status
	input  wire logic        init_done,		// initialisation finished
	input  wire logic        motor_stopped,		// motor at standstill
	input  wire logic        qs_to_disabled,	// quick stop action ends in disabled
	input  wire logic        alarm_in,		// alarm from alarm handling
	input  wire logic [15:0] alarm_code,		// code of that alarm
	// object access
	input  wire logic        obj_wr_en,
	input  wire logic        obj_rd_en,
	input  wire logic [15:0] obj_index,
	input  wire logic [15:0] obj_wdata,
	output logic      [15:0] obj_rdata_ff,
	output logic             obj_rd_hit_ff,
	output logic             obj_wr_ok_ff,
	output logic             obj_wr_refused_ff,
	// drive outputs
	output mds_state_t       state_ff,
	output logic      [15:0] status_word_ff,
	output logic      [15:0] error_code_ff,
	output logic      [15:0] command_word_ff,
	output logic             motor_excite_ff,
	output logic             stop_request_ff,
	output logic             drive_command_ready_output
);

	// ------------------------------------------------------------------
	// per-axis index map
	// ------------------------------------------------------------------
	localparam logic [15:0] AXIS_OFS = 16'((AXIS_NUM - 1) * IDX_AXIS_STRIDE);
	localparam logic [15:0] A_ERR    = IDX_ERROR_CODE + AXIS_OFS;
	localparam logic [15:0] A_CMD    = IDX_COMMAND_WORD + AXIS_OFS;
	localparam logic [15:0] A_STAT   = IDX_STATUS_WORD + AXIS_OFS;
	localparam logic [15:0] A_LO     = IDX_PROFILE_BASE + AXIS_OFS;

	// index lies inside this axis's profile area
	function automatic logic in_axis(input logic [15:0] idx);
		in_axis = (idx >= A_LO) && (idx <= A_LO + IDX_PROFILE_SPAN);
	endfunction

	// ------------------------------------------------------------------
	// synchronised pins
	// ------------------------------------------------------------------
	logic [3:0] pins_s;	// comm, power, release, remote test
	logic       comm_s;
	logic       power_s;
	logic       release_s;
	logic       rtest_s;

	mds_sync #(.WIDTH(4)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({remote_test_active, motor_release, main_power_on, comm_operational}),
		.sync_out (pins_s)
	);

	assign comm_s    = pins_s[0];
	assign power_s   = pins_s[1];
	assign release_s = pins_s[2];
	assign rtest_s   = pins_s[3];

	// ------------------------------------------------------------------
	// derived conditions
	// ------------------------------------------------------------------
	mds_state_t  nxt_state;		// next drive state
	logic [15:0] nxt_err;		// next error code
	logic        fr_prev_ff;	// fault reset bit one cycle ago
	logic        fr_edge;		// rising edge of fault reset
	logic        guards_ok;		// all conditions for switching on
	logic        loss;		// link or power gone
	logic        running;		// motor not at standstill
	logic        timer_done;	// excitation settled
	logic        excite_nxt;	// next excitation level

	assign fr_edge   = command_word_ff[CW_FAULT_RESET] & ~fr_prev_ff;
	assign guards_ok = comm_s & power_s & ~release_s & ~rtest_s;
	assign loss      = ~comm_s | ~power_s;
	assign running   = ~motor_stopped;

	// ------------------------------------------------------------------
	// next state; external alarm has top priority, then release in operation enabled and quick stop
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_err   = error_code_ff;
		case (state_ff)
			ST_NOT_READY:
				if (init_done)
					nxt_state = ST_SO_DISABLE;
			ST_SO_DISABLE:
				if (alarm_in)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = alarm_code;
				end
				else if (cw_shutdown(command_word_ff))
					nxt_state = ST_READY;
			ST_READY:
				if (alarm_in)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = alarm_code;
				end
				else if (cw_dis_voltage(command_word_ff) || cw_quick_stop(command_word_ff))
					nxt_state = ST_SO_DISABLE;
				else if (cw_enable_op(command_word_ff) && guards_ok)
					nxt_state = ST_OPER_EN;
				else if (cw_switch_on(command_word_ff) && guards_ok)
					nxt_state = ST_SWITCHED;
			ST_SWITCHED:
				if (alarm_in)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = alarm_code;
				end
				else if (cw_dis_voltage(command_word_ff) || cw_quick_stop(command_word_ff))
					nxt_state = ST_SO_DISABLE;
				else if (loss || release_s || cw_shutdown(command_word_ff))
					nxt_state = ST_READY;
				else if (cw_enable_op(command_word_ff))
					nxt_state = ST_OPER_EN;
			ST_OPER_EN:
				if (alarm_in)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = alarm_code;
				end
				else if (release_s || (loss && !running))
					nxt_state = ST_READY;
				else if (!comm_s)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = ALM_BUS_ERROR;
				end
				else if (!power_s)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = ALM_POWER_OFF;
				end
				else if (cw_dis_voltage(command_word_ff))
					nxt_state = ST_SO_DISABLE;
				else if (cw_quick_stop(command_word_ff))
					nxt_state = ST_QUICK_STOP;
				else if (cw_shutdown(command_word_ff))
					nxt_state = ST_READY;
				else if (cw_switch_on(command_word_ff))
					nxt_state = ST_SWITCHED;
			ST_QUICK_STOP:
				if (alarm_in)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = alarm_code;
				end
				else if (release_s || (loss && !running))
					nxt_state = ST_SO_DISABLE;
				else if (!comm_s)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = ALM_BUS_ERROR;
				end
				else if (!power_s)
				begin
					nxt_state = ST_FAULT_REAC;
					nxt_err   = ALM_POWER_OFF;
				end
				else if (cw_dis_voltage(command_word_ff))
					nxt_state = ST_SO_DISABLE;
				else if (cw_enable_op(command_word_ff))
					nxt_state = ST_OPER_EN;
				else if (qs_to_disabled && !running)
					nxt_state = ST_SO_DISABLE;
			ST_FAULT_REAC:
				if (!running)
					nxt_state = ST_FAULT;
			ST_FAULT:
				if (fr_edge)
				begin
					nxt_state = ST_SO_DISABLE;
					nxt_err   = ERR_NONE;
				end
			default:
				nxt_state = ST_NOT_READY;
		endcase
	end

	// excitation follows the state the machine is entering
	assign excite_nxt = (nxt_state == ST_OPER_EN) || (nxt_state == ST_QUICK_STOP)
		|| (nxt_state == ST_FAULT_REAC);

	// ------------------------------------------------------------------
	// state, error code and excitation registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff        <= ST_NOT_READY;
			error_code_ff   <= ERR_NONE;
			motor_excite_ff <= 1'b0;
			stop_request_ff <= 1'b0;
			fr_prev_ff      <= 1'b0;
		end
		else
		begin
			state_ff        <= nxt_state;
			error_code_ff   <= nxt_err;
			motor_excite_ff <= excite_nxt;
			// quick stop and fault reaction ask motion logic to halt
			stop_request_ff <= (nxt_state == ST_QUICK_STOP) || (nxt_state == ST_FAULT_REAC);
			fr_prev_ff      <= command_word_ff[CW_FAULT_RESET];
		end
	end

	// ------------------------------------------------------------------
	// excitation settling; motion commands wait for command ready
	// ------------------------------------------------------------------
	mds_excite_timer #(.CYCLES(EXCITE_CYCLES)) u_timer (
		.clk   (clk),
		.reset (reset),
		.run   (state_ff == ST_OPER_EN),
		.done  (timer_done)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			drive_command_ready_output <= 1'b0;
		else
			drive_command_ready_output <= timer_done && (nxt_state == ST_OPER_EN);
	end

	// ------------------------------------------------------------------
	// status word: state in bits 6..0, bit 4 shows main power
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			status_word_ff <= 16'h0000;
		else
		begin
			status_word_ff                <= 16'h0000;
			status_word_ff[SW_VOLTAGE]    <= power_s;
			status_word_ff[SW_SO_DISABLE] <= (nxt_state == ST_SO_DISABLE);
			status_word_ff[SW_FAULT]      <= (nxt_state == ST_FAULT)
				|| (nxt_state == ST_FAULT_REAC);
			status_word_ff[SW_QUICK_STOP] <= !(nxt_state inside {ST_NOT_READY,
				ST_QUICK_STOP});
			status_word_ff[SW_READY]      <= nxt_state inside {ST_READY, ST_SWITCHED,
				ST_OPER_EN, ST_QUICK_STOP, ST_FAULT_REAC};
			status_word_ff[SW_SWITCHED]   <= nxt_state inside {ST_SWITCHED, ST_OPER_EN,
				ST_QUICK_STOP, ST_FAULT_REAC};
			status_word_ff[SW_OPER_EN]    <= nxt_state inside {ST_OPER_EN,
				ST_QUICK_STOP, ST_FAULT_REAC};
		end
	end

	// ------------------------------------------------------------------
	// object writes: command word stored whole, bits 10..15 kept as written
	// read-only objects refuse, other indices of this axis are parameters
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			command_word_ff   <= CW_RESET;
			obj_wr_ok_ff      <= 1'b0;
			obj_wr_refused_ff <= 1'b0;
		end
		else
		begin
			obj_wr_ok_ff      <= 1'b0;
			obj_wr_refused_ff <= 1'b0;
			if (obj_wr_en && in_axis(obj_index))
			begin
				if (state_ff == ST_NOT_READY)
					obj_wr_refused_ff <= 1'b1;
				else if (obj_index == A_ERR || obj_index == A_STAT)
					obj_wr_refused_ff <= 1'b1;
				else
				begin
					obj_wr_ok_ff <= 1'b1;
					if (obj_index == A_CMD)
						command_word_ff <= obj_wdata;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// object reads, answered the next cycle; misses read as zero
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			obj_rdata_ff  <= 16'h0000;
			obj_rd_hit_ff <= 1'b0;
		end
		else
		begin
			obj_rd_hit_ff <= obj_rd_en && (obj_index inside {A_ERR, A_CMD, A_STAT});
			if (obj_rd_en && obj_index == A_ERR)
				obj_rdata_ff <= error_code_ff;
			else if (obj_rd_en && obj_index == A_CMD)
				obj_rdata_ff <= command_word_ff;
			else if (obj_rd_en && obj_index == A_STAT)
				obj_rdata_ff <= status_word_ff;
			else
				obj_rdata_ff <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_fault_entry;
		(state_ff == ST_FAULT_REAC) && motor_excite_ff;
	endsequence

	sequence s_fault_settle;
		(state_ff == ST_FAULT) && !motor_excite_ff;
	endsequence

	start_state_a: assert property (@(posedge clk) $past(reset) |-> state_ff == ST_NOT_READY && !motor_excite_ff) else $error("not in start state after reset");
	excite_map_a: assert property (@(posedge clk) disable iff (reset) motor_excite_ff == (state_ff inside {ST_OPER_EN, ST_QUICK_STOP, ST_FAULT_REAC})) else $error("excitation does not match state");
	init_move_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_NOT_READY && init_done |=> state_ff == ST_SO_DISABLE) else $error("init did not leave not ready");
	notready_write_a: assert property (@(posedge clk) disable iff (reset) obj_wr_en && in_axis(obj_index) && state_ff == ST_NOT_READY |=> obj_wr_refused_ff && !obj_wr_ok_ff && $stable(command_word_ff)) else $error("write taken while not ready");
	ready_guard_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_READY && !guards_ok |=> !(state_ff inside {ST_SWITCHED, ST_OPER_EN})) else $error("switched on without guards");
	direct_enable_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_READY && guards_ok && !alarm_in && command_word_ff[3:0] == 4'hF |=> state_ff == ST_OPER_EN) else $error("1111 did not reach operation enabled");
	fault_reset_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_FAULT && !fr_edge |=> state_ff == ST_FAULT) else $error("fault left without rising reset");
	cmd_ready_a: assert property (@(posedge clk) disable iff (reset) $rose(state_ff == ST_OPER_EN) |-> !drive_command_ready_output [*2]) else $error("command ready too early");
	ready_state_a: assert property (@(posedge clk) disable iff (reset) drive_command_ready_output |-> state_ff == ST_OPER_EN) else $error("command ready outside operation enabled");
	fault_path_a: assert property (@(posedge clk) disable iff (reset) s_fault_entry and !alarm_in && motor_stopped |=> s_fault_settle) else $error("fault reaction did not settle");
	switched_loss_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_SWITCHED && !alarm_in && command_word_ff[2:1] == 2'h3 && (loss || release_s) |=> state_ff == ST_READY) else $error("switched on kept after loss");
	oper_release_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_OPER_EN && !alarm_in && release_s |=> state_ff == ST_READY && !motor_excite_ff) else $error("release not honoured");
	bus_alarm_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_OPER_EN && !alarm_in && !release_s && !comm_s && running |=> state_ff == ST_FAULT_REAC && error_code_ff == ALM_BUS_ERROR) else $error("bus alarm missing");
	power_alarm_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_QUICK_STOP && !alarm_in && !release_s && comm_s && !power_s && running |=> state_ff == ST_FAULT_REAC && error_code_ff == ALM_POWER_OFF) else $error("power alarm missing");
	qs_release_a: assert property (@(posedge clk) disable iff (reset) state_ff == ST_QUICK_STOP && !alarm_in && release_s |=> state_ff == ST_SO_DISABLE && !motor_excite_ff) else $error("quick stop kept after release");

endmodule

/* sim/mds_master.sv */
// fieldbus master model: writes and reads objects of the drive
// assumes the object port answers on the edge after the request
module mds_master
	import mds_pkg::*;
(
	// clock
	input  wire logic        clk,
	// object port
	output logic             obj_wr_en,
	output logic             obj_rd_en,
	output logic      [15:0] obj_index,
	output logic      [15:0] obj_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle port at time zero
	initial
	begin
		obj_wr_en = 1'b0;
		obj_rd_en = 1'b0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end
	// one request cycle; command patterns come from the caller
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] dat);
		@(posedge clk);
		#1;
		obj_wr_en = wr;
		obj_rd_en = ~wr;
		obj_index = idx;
		obj_wdata = dat;
		@(posedge clk);
		#1;
		// released lines show the inverse so stale values never look valid
		obj_wr_en = 1'b0;
		obj_rd_en = 1'b0;
		obj_index = ~idx;
		obj_wdata = ~dat;
	endtask
endmodule

/* sim/tb.sv */
// bench for the drive state machine of axis 2, with a shortened settling time
// assumes the master model owns the object port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mds_pkg::*;
	localparam int EXC = 8;
	localparam logic [15:0] OFS = 16'h0800;
	localparam logic [15:0] ALM_X = 16'h0030;	// arbitrary alarm code from alarm handling
	logic clk, reset, comm, pwr, rel, init, stopd, rtst, alm;
	logic wr, rd, hit, ok, refd, exc, rdy;
	logic [15:0] idx, wd, rdat;
	mds_state_t st;
	int fails, checks;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
$display("unexpected at %0t: got %h want %h", $time, a, b); end end
	// free running clock, 40 ns
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	mds_master m (.clk(clk), .obj_wr_en(wr), .obj_rd_en(rd), .obj_index(idx), .obj_wdata(wd));
	mds_drive_fsm #(.AXIS_NUM(2), .EXCITE_CYCLES(EXC)) dut (.clk(clk), .reset(reset),
		.comm_operational(comm), .main_power_on(pwr), .motor_release(rel),
		.remote_test_active(rtst), .init_done(init), .motor_stopped(stopd),
		.qs_to_disabled(1'b0), .alarm_in(alm), .alarm_code(ALM_X),
		.obj_wr_en(wr), .obj_rd_en(rd), .obj_index(idx), .obj_wdata(wd),
		.obj_rdata_ff(rdat), .obj_rd_hit_ff(hit), .obj_wr_ok_ff(ok),
		.obj_wr_refused_ff(refd), .state_ff(st), .status_word_ff(), .error_code_ff(),
		.command_word_ff(), .motor_excite_ff(exc), .stop_request_ff(),
		.drive_command_ready_output(rdy));
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// wait a bounded time for a state; pins need three cycles to land
	task automatic wait_st(input mds_state_t s);
		for (int i = 0; i < 20 && st !== s; i++) @(posedge clk) #1;
		`CHK(st, s)
	endtask
	task automatic wcw(input logic [15:0] d);
		m.xfer(1'b1, IDX_COMMAND_WORD + OFS, d);
	endtask
	// hang guard
	initial
	begin
		#80000;
		fails++;
		finish_test();
	end
	// main sequence
	initial
	begin
		{reset, comm, pwr, rel, init, stopd, rtst, alm, fails, checks} = '0;
		reset = 1'b1;
		{comm, pwr} = 2'b11;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		`CHK(st, ST_NOT_READY)
		`CHK(exc, 1'b0)
		wcw(16'h0006);
		`CHK(refd, 1'b1)
		init = 1'b1;
		wait_st(ST_SO_DISABLE);
		wcw(16'h0006);
		`CHK(ok, 1'b1)
		wait_st(ST_READY);
		rel = 1'b1;
		repeat (4) @(posedge clk) #1;
		wcw(16'h000F);
		repeat (6) @(posedge clk) #1;
		`CHK(st, ST_READY)
		rel = 1'b0;
		rtst = 1'b1;
		repeat (6) @(posedge clk) #1;
		`CHK(st, ST_READY)
		rtst = 1'b0;
		wait_st(ST_OPER_EN);
		`CHK(exc, 1'b1)
		`CHK(rdy, 1'b0)
		repeat (EXC + 3) @(posedge clk) #1;
		`CHK(rdy, 1'b1)
		m.xfer(1'b0, IDX_STATUS_WORD + OFS, 16'h0000);
		`CHK(rdat, 16'h0037)
		comm = 1'b0;
		wait_st(ST_FAULT_REAC);
		stopd = 1'b1;
		wait_st(ST_FAULT);
		`CHK(exc, 1'b0)
		m.xfer(1'b0, IDX_ERROR_CODE + OFS, 16'h0000);
		`CHK(hit, 1'b1)
		`CHK(rdat, ALM_BUS_ERROR)
		m.xfer(1'b1, IDX_ERROR_CODE + OFS, 16'h0000);
		`CHK(refd, 1'b1)
		comm = 1'b1;
		wcw(16'h0080);
		wait_st(ST_SO_DISABLE);
		wcw(16'h0006);
		wait_st(ST_READY);
		wcw(16'h000F);
		wait_st(ST_OPER_EN);
		rel = 1'b1;
		wait_st(ST_READY);
		`CHK(exc, 1'b0)
		alm = 1'b1;
		wait_st(ST_FAULT);
		alm = 1'b0;
		`CHK(exc, 1'b0)
		m.xfer(1'b0, IDX_ERROR_CODE + OFS, 16'h0000);
		`CHK(rdat, ALM_X)
		$display("drive sequence test done");
		finish_test();
	end
endmodule
